//--- rfw_pkg.sv
// constants and state encoding for the remote fast write arbiter
// Contract
// [RULE_01] Machine idles until remote access enable and write strobe are both active.
// [RULE_02] Write during lock-out or local grant waits in second idle state.
// [RULE_03] Idle states grant local bus to timing unit when requested and lock high.
// [RULE_04] Acknowledge goes low as soon as enable and write strobe are active.
// [RULE_05] Without lock-out, arbitration follows next clock when no local request pends.
// [RULE_06] After idle, no local grants; local data access waits until termination.
// [RULE_07] Half T-state into arbitration, address and data buses float.
// [RULE_08] Access entry: own local bus, keep ack low, load both wait counters.
// [RULE_09] Instruction target with high byte flag set pulses instruction write in entry.
// [RULE_10] Command select writes configuration register; mode change applies one T-state later.
// [RULE_11] Memory select 10 or 11 loads program counter low or high byte.
// [RULE_12] Select 00 asserts data write with buses floating for data wait states.
// [RULE_13] Select 01 latches low byte, or writes high plus latched low word.
// [RULE_14] Reset and writing select 01 both clear the high byte flag.
// [RULE_15] Wait input low before last wait state ends extends access while low.
// [RULE_16] After waits with wait high, termination: own bus, float, ack high.
// [RULE_17] Next clock releases ownership, float half T-state, then grant local requests.
// [RULE_18] After instruction write, toggle high byte flag; increment counter after high byte.
// [RULE_19] Cycle ends once data written; idle after enable with write drops.
// [RULE_20] Host holds write strobe while ack low, drops it after ack high.
// [RULE_21] From a local write, wait one T-state after taking ownership before switching.
// [RULE_22] Address settles one T-state before write; ack returns after data waits.
// [RULE_23] Strobe still active after termination holds machine until it drops.
package rfw_pkg;
	localparam int unsigned CLOCK_HZ = 20000000;
	localparam logic [1:0] SEL_DATA = 2'h0;
	localparam logic [1:0] SEL_INSTR = 2'h1;
	localparam logic [1:0] SEL_PC_LO = 2'h2;
	localparam logic [1:0] SEL_PC_HI = 2'h3;
	localparam logic [1:0] SEL_RST = 2'h0;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam int unsigned CFG_SEL_LSB = 0;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [2:0] WAIT_ZERO = 3'h0;
	typedef enum logic [3:0] {
		S_IDLE1 = 4'h0,
		S_IDLE2 = 4'h1,
		S_ARB = 4'h3,
		S_ENTRY = 4'h2,
		S_ACCESS = 4'h6,
		S_TERM = 4'h7,
		S_RELEASE = 4'h5,
		S_HOLD = 4'h4
	} rfw_state_e;
	typedef enum logic [2:0] {
		T_CFG = 3'h0,
		T_PC_LO = 3'h1,
		T_PC_HI = 3'h2,
		T_DATA = 3'h3,
		T_ILO = 3'h4,
		T_IHI = 3'h5
	} rfw_target_e;
endpackage

//--- rfw_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module rfw_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clock) begin
		if (srst) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else if (clk_en) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

//--- rfw_wait_counter.sv
// loadable down counter for programmed wait states
`timescale 1ns/100ps
module rfw_wait_counter #(
	parameter int unsigned WIDTH = 3
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_val,
	input wire logic count,
	output logic done
);
	logic [WIDTH-1:0] cnt_r;

	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_r <= '0;
		end else if (clk_en) begin
			if (load) begin
				cnt_r <= load_val;
			end else if (count && cnt_r != '0) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	assign done = (cnt_r == '0);
endmodule

//--- remote_fast_write_arbiter.sv
// remote access state machine in fast buffered write mode
`timescale 1ns/100ps
module remote_fast_write_arbiter #(
	parameter int unsigned IW_WIDTH = 2,
	parameter int unsigned DW_WIDTH = 3
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic remote_access_enable,
	input wire logic remote_write_strobe_n,
	input wire logic cmd_select,
	input wire logic wait_n,
	input wire logic [7:0] remote_data,
	input wire logic lock_out_remote,
	input wire logic bus_lock,
	input wire logic local_bus_request,
	input wire logic local_data_access,
	input wire logic [IW_WIDTH-1:0] instr_wait_count,
	input wire logic [DW_WIDTH-1:0] data_wait_count,
	output logic transfer_ack_n,
	output logic local_bus_own_n,
	output logic local_bus_grant,
	output logic cpu_remote_wait,
	output logic bus_float,
	output logic data_mem_write_n,
	output logic instr_mem_write_n,
	output logic [15:0] instr_word,
	output logic [7:0] instr_low_latch,
	output logic [15:0] prog_counter,
	output logic [7:0] remote_interface_config,
	output logic [1:0] memory_select,
	output logic high_instr_byte_flag
);
	import rfw_pkg::*;

	// ----------------------------------------------------------------
	// input synchronisation
	// ----------------------------------------------------------------
	logic rae_s;
	logic wr_n_s;
	logic cmd_s;
	logic wait_n_s;
	logic [7:0] data_s;

	// reset value matches idle pins: enable low, strobe high, command low, wait high
	rfw_sync #(.WIDTH(12), .RST_VAL(12'h005)) u_sync (
		.clock(clock),
		.srst(srst),
		.clk_en(clk_en),
		.d({remote_data, remote_access_enable, remote_write_strobe_n,
			cmd_select, wait_n}),
		.q({data_s, rae_s, wr_n_s, cmd_s, wait_n_s})
	);

	// ----------------------------------------------------------------
	// state and decode
	// ----------------------------------------------------------------
	rfw_state_e state_r;
	rfw_state_e state_nxt;
	rfw_target_e target_r;
	logic remote_wr;
	logic grant_r;
	logic half_r;
	logic wait_done;
	logic wait_load;
	logic [7:0] cfg_pend_r;
	logic cfg_pend_valid_r;

	assign remote_wr = rae_s && !wr_n_s;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			// idle until enable with write
			S_IDLE1: begin
				// [RULE_01] wait for write
				if (remote_wr) begin
					// [RULE_02] locked or locally granted
					if (lock_out_remote || grant_r) begin
						state_nxt = S_IDLE2;
					// [RULE_05] free to arbitrate
					end else if (!local_bus_request) begin
						state_nxt = S_ARB;
					end
				end
			end
			S_IDLE2: begin
				// [RULE_02] stay while blocked
				if (!remote_wr) begin
					state_nxt = S_IDLE1;
				end else if (!lock_out_remote && !grant_r && !local_bus_request) begin
					state_nxt = S_ARB;
				end
			end
			S_ARB: state_nxt = S_ENTRY;
			S_ENTRY: state_nxt = S_ACCESS;
			S_ACCESS: begin
				// [RULE_15] extend while wait low
				if (wait_done && wait_n_s) begin
					state_nxt = S_TERM;
				end
			end
			S_TERM: state_nxt = S_RELEASE;
			S_RELEASE: begin
				// [RULE_23] one strobe, one write
				state_nxt = remote_wr ? S_HOLD : S_IDLE1;
			end
			S_HOLD: begin
				// [RULE_19] back to idle after strobe drops
				if (!remote_wr) begin
					state_nxt = S_IDLE1;
				end
			end
			default: state_nxt = S_IDLE1;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_r <= S_IDLE1;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// half T-state marker: float held through the whole release cycle, grant modelled as one cycle lag after release
	always_ff @(posedge clock) begin
		if (srst) begin
			half_r <= 1'b0;
		end else if (clk_en) begin
			half_r <= (state_r == S_RELEASE);
		end
	end

	// target select captured at access entry
	always_ff @(posedge clock) begin
		if (srst) begin
			target_r <= T_CFG;
		end else if (clk_en && state_r == S_ENTRY) begin
			// [RULE_10] command select first
			if (cmd_s) begin
				target_r <= T_CFG;
			end else begin
				unique case (memory_select)
					SEL_PC_LO: target_r <= T_PC_LO;
					// [RULE_11] program counter bytes
					SEL_PC_HI: target_r <= T_PC_HI;
					SEL_DATA: target_r <= T_DATA;
					SEL_INSTR: target_r <= high_instr_byte_flag ? T_IHI : T_ILO;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// wait state counters
	// ----------------------------------------------------------------
	logic iw_done;
	logic dw_done;
	logic [DW_WIDTH-1:0] iw_ext;

	// [RULE_08] load both counters in arbitration, so they hold their values at entry
	assign wait_load = (state_r == S_ARB);
	assign iw_ext = DW_WIDTH'(instr_wait_count);

	rfw_wait_counter #(.WIDTH(DW_WIDTH)) u_iw (
		.clock(clock),
		.srst(srst),
		.clk_en(clk_en),
		.load(wait_load),
		.load_val(iw_ext),
		.count(state_r == S_ACCESS && target_r == T_IHI),
		.done(iw_done)
	);

	rfw_wait_counter #(.WIDTH(DW_WIDTH)) u_dw (
		.clock(clock),
		.srst(srst),
		.clk_en(clk_en),
		.load(wait_load),
		.load_val(data_wait_count),
		.count(state_r == S_ACCESS && target_r == T_DATA),
		.done(dw_done)
	);

	// [RULE_22] data waits gate the ack return
	assign wait_done = (target_r == T_DATA) ? dw_done : ((target_r == T_IHI) ? iw_done : 1'b1);

	// ----------------------------------------------------------------
	// bus arbitration outputs
	// ----------------------------------------------------------------
	logic idle_state;
	assign idle_state = (state_r == S_IDLE1) || (state_r == S_IDLE2);

	// [RULE_03] grant in idle; [RULE_17] grant after release half T-state
	always_ff @(posedge clock) begin
		if (srst) begin
			grant_r <= 1'b0;
		end else if (clk_en) begin
			if (!local_bus_request) begin
				grant_r <= 1'b0;
			// [RULE_06] no grants outside idle and the cycle after release
			end else if ((idle_state || half_r) && bus_lock && state_nxt != S_ARB) begin
				grant_r <= 1'b1;
			end
		end
	end
	assign local_bus_grant = grant_r;

	// [RULE_04] ack low as soon as enable with write, until termination
	assign transfer_ack_n = !((remote_wr && (idle_state || state_r == S_ARB))
		|| state_r == S_ENTRY || state_r == S_ACCESS);

	// [RULE_06] local data access waits until termination
	assign cpu_remote_wait = local_data_access &&
		(state_r == S_ARB || state_r == S_ENTRY || state_r == S_ACCESS);

	// [RULE_08] ownership during access; [RULE_16] kept in termination
	assign local_bus_own_n = !(state_r == S_ENTRY || state_r == S_ACCESS || state_r == S_TERM);

	// [RULE_07] float from arbitration; [RULE_17] until release half
	assign bus_float = (state_r == S_ARB) || !local_bus_own_n || (state_r == S_RELEASE);

	// [RULE_21] entry cycle gives one T-state before the data write
	// [RULE_12] data write with buses floating
	assign data_mem_write_n = !(state_r == S_ACCESS && target_r == T_DATA);

	// [RULE_09] instruction write from entry when high byte expected
	assign instr_mem_write_n = !((state_r == S_ENTRY && !cmd_s && memory_select == SEL_INSTR
		&& high_instr_byte_flag) || (state_r == S_ACCESS && target_r == T_IHI));

	// ----------------------------------------------------------------
	// data paths
	// ----------------------------------------------------------------
	logic access_first;
	always_ff @(posedge clock) begin
		if (srst) begin
			access_first <= 1'b0;
		end else if (clk_en) begin
			access_first <= (state_r == S_ENTRY);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			instr_low_latch <= 8'h00;
			instr_word <= 16'h0000;
		end else if (clk_en && access_first && state_r == S_ACCESS) begin
			// [RULE_13] low byte latched, high byte writes word
			if (target_r == T_ILO) begin
				instr_low_latch <= data_s;
			end else if (target_r == T_IHI) begin
				instr_word <= {data_s, instr_low_latch};
			end
		end
	end

	// configuration write staged, applied on the clock that ends the release state
	always_ff @(posedge clock) begin
		if (srst) begin
			cfg_pend_r <= CFG_RST;
			cfg_pend_valid_r <= 1'b0;
			remote_interface_config <= CFG_RST;
		end else if (clk_en) begin
			// [RULE_10] delayed mode change
			if (access_first && state_r == S_ACCESS && target_r == T_CFG) begin
				cfg_pend_r <= data_s;
			end
			cfg_pend_valid_r <= (state_r == S_TERM && target_r == T_CFG);
			if (cfg_pend_valid_r) begin
				remote_interface_config <= cfg_pend_r;
			end
		end
	end
	assign memory_select = remote_interface_config[CFG_SEL_LSB +: 2];

	// [RULE_11] program counter loads; [RULE_18] increment after high byte
	always_ff @(posedge clock) begin
		if (srst) begin
			prog_counter <= PC_RST;
		end else if (clk_en) begin
			if (access_first && state_r == S_ACCESS && target_r == T_PC_LO) begin
				prog_counter[7:0] <= data_s;
			end else if (access_first && state_r == S_ACCESS && target_r == T_PC_HI) begin
				prog_counter[15:8] <= data_s;
			end else if (state_r == S_TERM && target_r == T_IHI) begin
				prog_counter <= prog_counter + 16'h0001;
			end
		end
	end

	// [RULE_14] reset and select 01 clear the flag; [RULE_18] toggle after instr write
	always_ff @(posedge clock) begin
		if (srst) begin
			high_instr_byte_flag <= 1'b0;
		end else if (clk_en) begin
			if (cfg_pend_valid_r && cfg_pend_r[CFG_SEL_LSB +: 2] == SEL_INSTR) begin
				high_instr_byte_flag <= 1'b0;
			end else if (state_r == S_TERM && (target_r == T_ILO || target_r == T_IHI)) begin
				high_instr_byte_flag <= !high_instr_byte_flag;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_ACK_LOW_IDLE: assert property (@(posedge clock) disable iff (srst) // [RULE_04]
		(idle_state && remote_wr) |-> !transfer_ack_n)
		else $error("ack not low on remote write");
	AST_ARB_TO_ENTRY: assert property (@(posedge clock) disable iff (srst || !clk_en) // [RULE_08]
		(state_r == S_ARB) |=> (state_r == S_ENTRY && !local_bus_own_n && !transfer_ack_n))
		else $error("entry not after arbitration");
	AST_TERM_ACK_HIGH: assert property (@(posedge clock) disable iff (srst) // [RULE_16]
		(state_r == S_TERM) |-> (transfer_ack_n && !local_bus_own_n && bus_float))
		else $error("termination outputs wrong");
	AST_RELEASE_OWN: assert property (@(posedge clock) disable iff (srst || !clk_en) // [RULE_17]
		(state_r == S_TERM) |=> (local_bus_own_n && bus_float))
		else $error("release outputs wrong");
	AST_NO_GRANT_BUSY: assert property (@(posedge clock) disable iff (srst || !clk_en) // [RULE_06]
		(state_r == S_ENTRY || state_r == S_ACCESS) |=> !$rose(local_bus_grant))
		else $error("grant during access");
	AST_LOCKOUT: assert property (@(posedge clock) disable iff (srst || !clk_en) // [RULE_02]
		(idle_state && lock_out_remote) |=> state_r != S_ARB)
		else $error("arbitration during lock-out");
	AST_WAIT_EXTEND: assert property (@(posedge clock) disable iff (srst || !clk_en) // [RULE_15]
		(state_r == S_ACCESS && !wait_n_s) |=> (state_r == S_ACCESS))
		else $error("access ended while wait low");
	AST_DATA_WRITE_FLOAT: assert property (@(posedge clock) disable iff (srst) // [RULE_12]
		!data_mem_write_n |-> (bus_float && !transfer_ack_n))
		else $error("data write without float");
	AST_FLAG_TOGGLE: assert property (@(posedge clock) disable iff (srst || !clk_en) // [RULE_18]
		(state_r == S_TERM && target_r == T_ILO && !cfg_pend_valid_r)
		|=> high_instr_byte_flag != $past(high_instr_byte_flag))
		else $error("flag not toggled");
	AST_HOLD: assert property (@(posedge clock) disable iff (srst || !clk_en) // [RULE_23]
		(state_r == S_RELEASE && remote_wr) |=> (state_r == S_HOLD))
		else $error("no hold on lingering strobe");
	AST_IDLE_STAY: assert property (@(posedge clock) disable iff (srst || !clk_en) // [RULE_01]
		(state_r == S_IDLE1 && !remote_wr) |=> (state_r == S_IDLE1))
		else $error("left idle without a write");
	AST_ARB_FLOAT: assert property (@(posedge clock) disable iff (srst) // [RULE_07]
		(state_r == S_ARB) |-> (bus_float && local_bus_own_n && !transfer_ack_n))
		else $error("arbitration outputs wrong");
	AST_CFG_DELAY: assert property (@(posedge clock) disable iff (srst || !clk_en) // [RULE_10]
		(state_r == S_TERM && target_r == T_CFG) |=> $stable(remote_interface_config))
		else $error("configuration applied too early");
endmodule

//--- remote_host_model.sv
// remote host model driving the write pins of the arbiter
`timescale 1ns/100ps
module remote_host_model (
	input wire logic clock,
	input wire logic start,
	input wire logic cmd,
	input wire logic [7:0] data,
	input wire logic [3:0] ext_wait,
	input wire logic [3:0] linger,
	input wire logic transfer_ack_n,
	output logic remote_access_enable,
	output logic remote_write_strobe_n,
	output logic cmd_select,
	output logic wait_n,
	output logic [7:0] remote_data,
	output logic busy,
	output logic late
);
	int n;
	// ----------------
	// write cycle
	// ----------------
	initial begin
		remote_access_enable = 1'b0;
		remote_write_strobe_n = 1'b1;
		cmd_select = 1'b0;
		wait_n = 1'b1;
		remote_data = 8'h00;
		busy = 1'b0;
		late = 1'b0;
		forever begin
			@(posedge clock);
			if (start === 1'b1) begin
				@(negedge clock);
				busy = 1'b1;
				cmd_select = cmd;
				remote_data = data;
				remote_access_enable = 1'b1;
				remote_write_strobe_n = 1'b0;
				wait_n = (ext_wait == 4'h0);
				n = 0;
				while (transfer_ack_n !== 1'b0 && n < 20) begin
					@(negedge clock);
					n++;
				end
				if (n >= 20) begin
					late = 1'b1;
				end
				repeat (ext_wait) @(negedge clock);
				wait_n = 1'b1;
				n = 0;
				while (transfer_ack_n !== 1'b1 && n < 200) begin
					@(negedge clock);
					n++;
				end
				if (n >= 200) begin
					late = 1'b1;
				end
				repeat (linger) @(negedge clock);
				remote_access_enable = 1'b0;
				remote_write_strobe_n = 1'b1;
				remote_data = ~remote_data;
				cmd_select = ~cmd_select;
				@(negedge clock);
				busy = 1'b0;
			end
		end
	end
endmodule

//--- remote_fast_write_arbiter_tb.sv
// self-checking bench for the remote fast write arbiter
`timescale 1ns/100ps
module remote_fast_write_arbiter_tb;
	import rfw_pkg::*;
	// ----------------
	// signals
	// ----------------
	logic clock, srst, remote_access_enable, remote_write_strobe_n, cmd_select, wait_n;
	logic lock_out_remote, bus_lock, local_bus_request, local_data_access;
	logic [7:0] remote_data;
	logic [1:0] instr_wait_count;
	logic [2:0] data_wait_count;
	logic transfer_ack_n, local_bus_own_n, local_bus_grant, cpu_remote_wait, bus_float;
	logic data_mem_write_n, instr_mem_write_n, high_instr_byte_flag;
	logic [15:0] instr_word, prog_counter, exp_pc, exp_word;
	logic [7:0] instr_low_latch, remote_interface_config, exp_cfg, exp_latch;
	logic [1:0] memory_select;
	logic exp_flag, start, h_cmd, busy, late, clk_en;
	logic [7:0] h_data;
	logic [3:0] h_ext, h_linger;
	logic [31:0] seed = 32'he2b90367;
	int fails, samples_checked, dw_low, iw_low, fl_seen, g_in_fl, cw_seen, i, k;

	remote_fast_write_arbiter i_dut (
		.clock, .srst, .clk_en, .remote_access_enable, .remote_write_strobe_n,
		.cmd_select, .wait_n, .remote_data, .lock_out_remote, .bus_lock,
		.local_bus_request, .local_data_access, .instr_wait_count, .data_wait_count,
		.transfer_ack_n, .local_bus_own_n, .local_bus_grant, .cpu_remote_wait, .bus_float,
		.data_mem_write_n, .instr_mem_write_n, .instr_word, .instr_low_latch,
		.prog_counter, .remote_interface_config, .memory_select, .high_instr_byte_flag
	);
	remote_host_model i_host (
		.clock, .start, .cmd(h_cmd), .data(h_data), .ext_wait(h_ext), .linger(h_linger),
		.transfer_ack_n, .remote_access_enable, .remote_write_strobe_n, .cmd_select,
		.wait_n, .remote_data, .busy, .late
	);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock) begin
		if (data_mem_write_n === 1'b0) dw_low++;
		if (instr_mem_write_n === 1'b0) iw_low++;
		if (cpu_remote_wait === 1'b1) cw_seen++;
		if (bus_float === 1'b1) begin
			fl_seen++;
			if (local_bus_grant === 1'b1) g_in_fl++;
		end
	end
	// ----------------
	// tasks
	// ----------------
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task cmp();
		chk(prog_counter, exp_pc); // counter
		chk(remote_interface_config, 16'(exp_cfg)); // config
		chk(memory_select, 16'(exp_cfg[1:0])); // select field
		chk(high_instr_byte_flag, 16'(exp_flag)); // flag
		chk(instr_low_latch, 16'(exp_latch)); // latch
		chk(instr_word, exp_word); // word
	endtask

	task wr_start(input logic c, input logic [7:0] d, input logic [3:0] e, input logic [3:0] l);
		repeat (3) @(negedge clock);
		dw_low = 0;
		iw_low = 0;
		fl_seen = 0;
		g_in_fl = 0;
		cw_seen = 0;
		{h_cmd, h_data, h_ext, h_linger} = {c, d, e, l};
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		if (c) begin
			exp_cfg = d;
			if (d[1:0] == SEL_INSTR) exp_flag = 1'b0;
		end else if (exp_cfg[1:0] == SEL_PC_LO) exp_pc[7:0] = d;
		else if (exp_cfg[1:0] == SEL_PC_HI) exp_pc[15:8] = d;
		else if (exp_cfg[1:0] == SEL_INSTR && !exp_flag) begin
			exp_latch = d;
			exp_flag = 1'b1;
		end else if (exp_cfg[1:0] == SEL_INSTR) begin
			exp_word = {d, exp_latch};
			exp_flag = 1'b0;
			exp_pc++;
		end
	endtask

	task wr_end();
		k = 0;
		@(posedge clock);
		while (busy !== 1'b0 && k < 400) begin
			@(posedge clock);
			k++;
		end
		if (k >= 400) begin
			fails++;
			conclude();
		end
		@(negedge clock);
		chk(late, 16'h0); // ack in time
		cmp(); // results
	endtask

	task wr(input logic c, input logic [7:0] d, input logic [3:0] e, input logic [3:0] l);
		wr_start(c, d, e, l);
		wr_end();
	endtask

	task cfgw(input logic [1:0] sel);
		logic [7:0] r;
		r = xs();
		wr(1'b1, {r[7:2], sel}, 4'h0, 4'h0);
	endtask
	// ----------------
	// sequence
	// ----------------
	initial begin
		{srst, start, h_cmd, h_data, h_ext, h_linger} = {1'b1, 18'h0};
		{clk_en, lock_out_remote, bus_lock, local_bus_request, local_data_access} = 5'h10;
		{instr_wait_count, data_wait_count} = 5'h0;
		{exp_pc, exp_word, exp_cfg, exp_latch, exp_flag} = {PC_RST, 16'h0, CFG_RST, 9'h0};
		repeat (8) @(negedge clock);
		srst = 1'b0;
		@(negedge clock);
		chk({transfer_ack_n, local_bus_own_n, bus_float, data_mem_write_n}, 4'hd); // idle
		cmp(); // reset values
		$display("test reset done");
		local_bus_request = 1'b1;
		repeat (6) @(negedge clock);
		chk(local_bus_grant, 16'h0); // lock low
		{bus_lock, clk_en} = 2'h2;
		repeat (4) @(negedge clock);
		chk(local_bus_grant, 16'h0); // frozen while disabled
		clk_en = 1'b1;
		repeat (4) @(negedge clock);
		chk(local_bus_grant, 16'h1); // grant given
		lock_out_remote = 1'b1;
		wr_start(1'b0, xs(), 4'h0, 4'h0);
		repeat (10) @(negedge clock);
		chk({bus_float, transfer_ack_n}, 16'h0); // held with ack low
		local_bus_request = 1'b0;
		repeat (6) @(negedge clock);
		chk(bus_float, 16'h0); // lock-out holds
		lock_out_remote = 1'b0;
		wr_end();
		chk(16'(dw_low), 16'h1); // write proceeds
		$display("test arbitration done");
		for (i = 0; i < 8; i++) begin
			data_wait_count = 3'(i);
			instr_wait_count = 2'(i);
			wr(1'b0, xs(), 4'h0, 4'(i % 3));
			chk(16'(dw_low), 16'(1 + i)); // write length
			chk(fl_seen > 0, 16'h1); // buses float
			chk({local_bus_own_n, transfer_ack_n, bus_float}, 16'h6); // released
		end
		data_wait_count = 3'h2;
		wr(1'b0, xs(), 4'h6, 4'h0);
		chk(dw_low > 3, 16'h1); // stretched
		$display("test data writes done");
		wr_start(1'b0, xs(), 4'h0, 4'h0);
		k = 0;
		while (bus_float !== 1'b1 && k < 50) begin
			@(posedge clock);
			k++;
		end
		if (k >= 50) begin
			fails++;
			conclude();
		end
		@(negedge clock);
		{local_bus_request, local_data_access} = 2'h3;
		wr_end();
		chk(cw_seen > 0, 16'h1); // cpu waited
		chk(16'(g_in_fl), 16'h0); // no grant while floating
		repeat (3) @(negedge clock);
		chk(local_bus_grant, 16'h1); // grant afterwards
		{local_bus_request, local_data_access} = 2'h0;
		$display("test local contention done");
		cfgw(SEL_PC_LO); // config write
		wr(1'b0, xs(), 4'h0, 4'h0);
		cfgw(SEL_PC_HI);
		wr(1'b0, xs(), 4'h0, 4'h0); // counter bytes
		$display("test counter load done");
		cfgw(SEL_INSTR);
		wr(1'b0, xs(), 4'h0, 4'h0);
		chk(16'(iw_low), 16'h0); // low byte only latched
		cfgw(SEL_INSTR); // select clears flag
		for (i = 0; i < 4; i++) begin
			instr_wait_count = 2'(i);
			wr(1'b0, xs(), 4'h0, 4'h0);
			wr(1'b0, xs(), 4'h0, 4'h0);
			chk(16'(iw_low), 16'(2 + i)); // word written
		end
		$display("test instruction words done");
		conclude();
	end
endmodule
